// ==== design/drs_top.sv ====
// Debug run status: control, trigger and status registers with run tracking
`timescale 1ns/10ps
module drs_top
  import drs_pkg::*;
(
  input  wire logic          CLK_SYS,    // System clock, 10 MHz
  input  wire logic          RST_N,      // Async reset, low
  input  wire logic [AW-1:0] ADDR,       // Register address
  input  wire logic [DW-1:0] WDATA,      // Write data
  input  wire logic          WR,         // Write strobe
  input  wire logic          RD,         // Read strobe
  output logic      [DW-1:0] RDATA,      // Read data, cycle after RD
  input  wire logic          SECURE,     // Blocks setting module enable
  input  wire logic          MATCH_A,    // Comparator A match pulse
  input  wire logic          MATCH_B,    // Comparator B match pulse
  input  wire logic          TRIG_EVENT, // Trigger event pulse
  input  wire logic          FIFO_FULL,  // Capture FIFO full
  input  wire logic [3:0]    FIFO_COUNT, // Valid words in FIFO
  output logic               ARMED       // Debugger armed
);

  drs_ctl_s   ctl;
  drs_trg_s   trg;
  drs_sts_s   sts;
  logic       wr_ctl;
  logic       wr_trg;
  logic       wr_sts;
  logic       rd_sts;
  logic       new_en;
  logic       new_arm;
  logic       armed_status_flag;
  logic       begin_mode;
  logic       auto_end;
  logic       manual_end;
  logic       run_start;
  logic       run_end;
  logic       af;
  logic       bf;
  logic [3:0] cnt;
  logic [DW-1:0] next_rdata;

  // Address decode
  always_comb begin
    wr_ctl = WR && (ADDR == OFS_CTL);
    wr_trg = WR && (ADDR == OFS_TRG);
    wr_sts = WR && (ADDR == OFS_STS);
    rd_sts = RD && (ADDR == OFS_STS);
  end

  // Proposed control bits of a control write
  always_comb begin
    new_en  = WDATA[CTL_EN_BIT] && (!SECURE || ctl.en);
    new_arm = WDATA[CTL_ARM_BIT];
  end

  assign armed_status_flag = ctl.en && ctl.arm;

  // Event-only modes always complete as begin traces
  always_comb begin
    begin_mode = trg.begin_trace || drs_event_only(trg.mode);
  end

  always_comb begin
    auto_end   = begin_mode ? FIFO_FULL : TRIG_EVENT;
    manual_end = wr_ctl && (!new_en || !new_arm);
    run_start  = wr_ctl && new_en && new_arm && !armed_status_flag;
    run_end    = armed_status_flag && (auto_end || manual_end);
  end

  // Control register; run end drops the arm bit
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctl <= '0;
    end else if (wr_ctl) begin
      ctl.en  <= new_en;
      ctl.arm <= new_arm && new_en && !(armed_status_flag && auto_end);
    end else if (run_end) begin
      ctl.arm <= 1'b0;
    end
  end

  // Trigger register, writable only while not armed
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      trg <= '0;
    end else if (wr_trg && !ctl.arm) begin
      trg.begin_trace <= WDATA[TRG_BEGIN_BIT];
      trg.mode        <= WDATA[TRG_MODE_LSB +: 4];
    end
  end

  drs_flag u_flag_a (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .clr   (run_start),
    .set   (armed_status_flag && MATCH_A),
    .flag  (af)
  );

  drs_flag u_flag_b (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .clr   (run_start),
    .set   (armed_status_flag && MATCH_B),
    .flag  (bf)
  );

  // Count reacts only to run start and end, never to FIFO reads
  drs_count u_count (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .start    (run_start),
    .stop     (run_end),
    .fifo_cnt (FIFO_COUNT),
    .cnt      (cnt)
  );

  // Status image; no write path reaches it
  always_comb begin
    sts.match_a = af;
    sts.match_b = bf;
    sts.armed   = armed_status_flag;
    sts.spare   = 1'b0;
    sts.cnt     = cnt;
  end

  always_comb begin
    next_rdata = RDATA_RST;
    if (RD) begin
      unique case (ADDR)
        OFS_CTL: begin
          next_rdata[CTL_EN_BIT]  = ctl.en;
          next_rdata[CTL_ARM_BIT] = ctl.arm;
        end
        OFS_TRG: begin
          next_rdata[TRG_BEGIN_BIT]      = trg.begin_trace;
          next_rdata[TRG_MODE_LSB +: 4]  = trg.mode;
        end
        OFS_STS: next_rdata = sts;
        default: next_rdata = RDATA_RST;
      endcase
    end
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= RDATA_RST;
    end else begin
      RDATA <= next_rdata;
    end
  end

  assign ARMED = armed_status_flag;

  // Assertions
  sequence seq_run_start;
    run_start;
  endsequence

  sequence seq_run_end;
    run_end;
  endsequence

  a_start_clears_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    seq_run_start |=> !af)
    else $error("A flag not cleared at run start");

  a_match_sets_a: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && MATCH_A) |=> af && sts.match_a)
    else $error("A flag not set by match");

  a_a_stays_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (!af && !(armed_status_flag && MATCH_A)) |=> !af)
    else $error("A flag set without match");

  a_start_clears_b: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    seq_run_start |=> !bf)
    else $error("B flag not cleared at run start");

  a_match_sets_b: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && MATCH_B) |=> bf && sts.match_b)
    else $error("B flag not set by match");

  a_armed_image: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (RD && ADDR == OFS_STS && ctl.en) |=> (RDATA[5] == $past(ctl.arm)))
    else $error("Armed flag differs from arm bit");

  a_arm_write_sets: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_ctl && WDATA[CTL_EN_BIT] && WDATA[CTL_ARM_BIT] && !SECURE && !armed_status_flag)
    |=> armed_status_flag ##0 ARMED)
    else $error("Arm write did not arm");

  a_auto_end: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && !wr_ctl && (begin_mode ? FIFO_FULL : TRIG_EVENT)) |=> !armed_status_flag)
    else $error("Run did not end on completion");

  a_end_trace_holds: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && !wr_ctl && !begin_mode && !TRIG_EVENT) |=> armed_status_flag)
    else $error("End trace ended without trigger");

  a_event_only_full: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && !wr_ctl && drs_event_only(trg.mode) && FIFO_FULL) |=> !armed_status_flag)
    else $error("Event-only run ignored full FIFO");

  a_manual_stop: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_ctl && (!WDATA[CTL_ARM_BIT] || !WDATA[CTL_EN_BIT])) |=> !armed_status_flag)
    else $error("Manual stop did not disarm");

  a_cnt_cleared: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    seq_run_start |=> (cnt == CNT_RST)
    ##1 (cnt == CNT_RST || $past(run_end)))
    else $error("Count not cleared at run start");

  a_cnt_capture: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    seq_run_end |=> cnt == (($past(FIFO_COUNT) > CNT_MAX) ? CNT_MAX
                            : $past(FIFO_COUNT)))
    else $error("Count not captured at run end");

  a_cnt_hold: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (!run_start && !run_end) |=> $stable(cnt))
    else $error("Count changed outside run edges");

  a_status_ro: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_sts && !armed_status_flag) |=> $stable(sts))
    else $error("Status write altered status");

  a_spare_zero: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    rd_sts |=> RDATA[4] == 1'b0 && RDATA[3:0] == $past(cnt))
    else $error("Status read mismatch");

  sequence seq_sts_read;
    rd_sts;
  endsequence

  sequence seq_bus_idle;
    !RD;
  endsequence

  a_status_image: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    seq_sts_read |=> RDATA == $past(sts))
    else $error("Status read differs from status image");

  a_rdata_idle: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    seq_bus_idle |=> RDATA == RDATA_RST)
    else $error("Read data not zero after idle cycle");

  a_b_stays_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (!bf && !(armed_status_flag && MATCH_B)) |=> !bf)
    else $error("B flag set without match");

  a_flags_frozen: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (!armed_status_flag && !run_start) |=> $stable(af) && $stable(bf))
    else $error("Match flag changed while not armed");

  a_start_match_lost: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (seq_run_start ##0 (MATCH_A || MATCH_B)) |=> !af && !bf)
    else $error("Match counted in the arming cycle");

  a_secure_blocks: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_ctl && SECURE && !ctl.en) |=> !ctl.en && !ARMED)
    else $error("Enable set while secure");

  a_arm_rise_cause: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $rose(ARMED) |-> $past(wr_ctl))
    else $error("Armed without a control write");

  a_arm_refresh: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && wr_ctl && new_en && new_arm && !auto_end) |=> armed_status_flag)
    else $error("Arm rewrite ended the run");

  a_refresh_ends: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (armed_status_flag && wr_ctl && auto_end) |=> !armed_status_flag)
    else $error("Completion lost under a control write");

  a_trg_locked: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (wr_trg && ctl.arm) |=> $stable(trg))
    else $error("Trigger setup changed while armed");

  a_cnt_bound: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    cnt <= CNT_MAX)
    else $error("Count above eight");

  a_cnt_zero_run: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    armed_status_flag |-> cnt == CNT_RST)
    else $error("Count not zero during run");

  a_ctl_readback: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (RD && ADDR == OFS_CTL) |=> RDATA[CTL_EN_BIT] == $past(ctl.en)
    && RDATA[CTL_ARM_BIT] == $past(ctl.arm))
    else $error("Control read back mismatch");

  a_unmapped_zero: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (RD && ADDR > OFS_STS) |=> RDATA == RDATA_RST)
    else $error("Unmapped read not zero");

endmodule // drs_top

// ==== design/drs_pkg.sv ====
// Package: register map, field positions and carrier types of debug run status
package drs_pkg;

  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;

  localparam logic [AW-1:0] OFS_CTL = 8'h00;
  localparam logic [AW-1:0] OFS_TRG = 8'h01;
  localparam logic [AW-1:0] OFS_STS = 8'h02;

  localparam int unsigned CTL_EN_BIT    = 7;
  localparam int unsigned CTL_ARM_BIT   = 6;
  localparam int unsigned TRG_BEGIN_BIT = 6;
  localparam int unsigned TRG_MODE_LSB  = 0;

  localparam logic [3:0] MODE_EVT_B      = 4'h3;
  localparam logic [3:0] MODE_A_EVT_B    = 4'h4;
  localparam logic [3:0] CNT_RST         = 4'h0;
  localparam logic [3:0] CNT_MAX         = 4'h8;
  localparam logic [DW-1:0] RDATA_RST    = 8'h00;

  typedef struct packed {
    logic en;
    logic arm;
  } drs_ctl_s;

  typedef struct packed {
    logic       begin_trace;
    logic [3:0] mode;
  } drs_trg_s;

  typedef struct packed {
    logic       match_a;
    logic       match_b;
    logic       armed;
    logic       spare;
    logic [3:0] cnt;
  } drs_sts_s;

  // True for trigger modes that only log events
  function automatic logic drs_event_only(input logic [3:0] mode);
    return (mode == MODE_EVT_B) || (mode == MODE_A_EVT_B);
  endfunction

endpackage

// ==== design/drs_flag.sv ====
// Sticky match flag cleared at run start and set by a qualified match
`timescale 1ns/10ps
module drs_flag
  import drs_pkg::*;
(
  input  wire logic clk,   // System clock
  input  wire logic rst_n, // Async reset, low
  input  wire logic clr,   // Run start
  input  wire logic set,   // Qualified match
  output logic      flag   // Sticky flag
);

  // Set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule // drs_flag

// ==== design/drs_count.sv ====
// FIFO valid count captured at the end of a debug run
`timescale 1ns/10ps
module drs_count
  import drs_pkg::*;
(
  input  wire logic       clk,      // System clock
  input  wire logic       rst_n,    // Async reset, low
  input  wire logic       start,    // Run start
  input  wire logic       stop,     // Run end
  input  wire logic [3:0] fifo_cnt, // Live FIFO word count
  output logic [3:0]      cnt       // Captured count
);

  logic [3:0] next_cnt;

  // Values above eight saturate at eight
  always_comb begin
    next_cnt = (fifo_cnt > CNT_MAX) ? CNT_MAX : fifo_cnt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CNT_RST;
    end else if (start) begin
      cnt <= CNT_RST;
    end else if (stop) begin
      cnt <= next_cnt;
    end
  end

endmodule // drs_count

// ==== sim/drs_host_model.sv ====
// Capture FIFO and debug host model facing the status block
`timescale 1ns/10ps
module drs_host_model (
  input  wire logic       clk,   // System clock
  input  wire logic       rst_n, // Async reset, low
  input  wire logic       clr,   // Empty the FIFO
  input  wire logic       push,  // Store one trace word
  input  wire logic       pop,   // Host reads one word
  output logic      [3:0] count, // Live word count
  output logic            full,  // Eight words held
  output logic      [3:0] tally  // Words the host has read
);
  assign full = (count == 4'h8);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) count <= 4'h0;
    else if (clr) count <= 4'h0;
    else if (push && !full) count <= count + 4'h1;
    else if (pop && count != 4'h0) count <= count - 4'h1;
  end
  // Own tally, the status count does not drop on host reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tally <= 4'h0;
    else if (clr) tally <= 4'h0;
    else if (pop && count != 4'h0) tally <= tally + 4'h1;
  end
endmodule // drs_host_model

// ==== sim/drs_top_tb_top.sv ====
// Self-checking bench of the debug run status block
`timescale 1ns/10ps
module drs_top_tb_top;
  import drs_pkg::*;
  `define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    miscompares++; end end
  logic          clk_sys = 1'b0, rst_n = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0, rdata;
  logic          wr = 1'b0, rd = 1'b0, secure = 1'b0, armed, ffull;
  logic          match_a = 1'b0, match_b = 1'b0, trig = 1'b0;
  logic          push = 1'b0, pop = 1'b0, clr = 1'b0;
  logic [3:0]    fcnt, tally;
  int            miscompares = 0, comparisons = 0;

  always #50 clk_sys = ~clk_sys;

  drs_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SECURE(secure),
    .MATCH_A(match_a), .MATCH_B(match_b), .TRIG_EVENT(trig),
    .FIFO_FULL(ffull), .FIFO_COUNT(fcnt), .ARMED(armed));
  drs_host_model host (.clk(clk_sys), .rst_n(rst_n), .clr(clr),
    .push(push), .pop(pop), .count(fcnt), .full(ffull), .tally(tally));

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clk_sys) begin wr <= 1'b1; addr <= a; wdata <= v; end
    @(posedge clk_sys) wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge clk_sys) begin rd <= 1'b1; addr <= a; end
    @(posedge clk_sys) rd <= 1'b0;
    #1 `CHK("read data", e, rdata)
  endtask
  task automatic step(input int n, input logic p, input logic q);
    @(posedge clk_sys) begin push <= p; pop <= q; end
    repeat (n - 1) @(posedge clk_sys);
    @(posedge clk_sys) begin push <= 1'b0; pop <= 1'b0; end
    #1;
  endtask
  task automatic new_run(input logic [DW-1:0] trg);
    @(posedge clk_sys) clr <= 1'b1;
    @(posedge clk_sys) clr <= 1'b0;
    wr_reg(OFS_TRG, trg);
    wr_reg(OFS_CTL, 8'hc0);
    `CHK("armed", 1'b1, armed)
  endtask

  task automatic t_flags;
    rd_reg(OFS_STS, 8'h00);
    rd_reg(8'h7f, 8'h00);
    @(posedge clk_sys) match_a <= 1'b1;
    @(posedge clk_sys) match_a <= 1'b0;
    new_run(8'h00);
    rd_reg(OFS_STS, 8'h20);
    @(posedge clk_sys) match_a <= 1'b1;
    @(posedge clk_sys) match_a <= 1'b0;
    rd_reg(OFS_STS, 8'ha0);
    @(posedge clk_sys) match_b <= 1'b1;
    @(posedge clk_sys) match_b <= 1'b0;
    rd_reg(OFS_STS, 8'he0);
    wr_reg(OFS_STS, 8'h1f);
    rd_reg(OFS_STS, 8'he0);
    wr_reg(OFS_CTL, 8'h80);
    rd_reg(OFS_STS, 8'hc0);
    new_run(8'h00);
    rd_reg(OFS_STS, 8'h20);
    wr_reg(OFS_CTL, 8'h40);
    `CHK("armed", 1'b0, armed)
  endtask
  task automatic t_begin;
    new_run(8'h40);
    step(8, 1'b1, 1'b0);
    @(posedge clk_sys) #1 `CHK("armed", 1'b0, armed)
    rd_reg(OFS_STS, 8'h08);
    step(3, 1'b0, 1'b1);
    rd_reg(OFS_STS, 8'h08);
    `CHK("host tally", 4'h3, tally)
  endtask
  task automatic t_end;
    new_run(8'h00);
    rd_reg(OFS_STS, 8'h20);
    step(8, 1'b1, 1'b0);
    @(posedge clk_sys) #1 `CHK("armed", 1'b1, armed)
    step(5, 1'b0, 1'b1);
    @(posedge clk_sys) trig <= 1'b1;
    @(posedge clk_sys) trig <= 1'b0;
    #1 `CHK("armed", 1'b0, armed)
    rd_reg(OFS_STS, 8'h03);
  endtask
  task automatic t_evt(input logic [DW-1:0] trg);
    new_run(trg);
    step(8, 1'b1, 1'b0);
    @(posedge clk_sys) #1 `CHK("armed", 1'b0, armed)
    rd_reg(OFS_STS, 8'h08);
  endtask
  task automatic t_refuse;
    wr_reg(OFS_CTL, 8'h00);
    @(posedge clk_sys) secure <= 1'b1;
    wr_reg(OFS_CTL, 8'hc0);
    `CHK("armed", 1'b0, armed)
    rd_reg(OFS_CTL, 8'h00);
    @(posedge clk_sys) secure <= 1'b0;
    new_run(8'h40);
    wr_reg(OFS_TRG, 8'h03);
    rd_reg(OFS_TRG, 8'h40);
    rd_reg(OFS_CTL, 8'hc0);
    step(2, 1'b1, 1'b0);
    wr_reg(OFS_CTL, 8'h40);
    `CHK("armed", 1'b0, armed)
    rd_reg(OFS_STS, 8'h02);
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_flags;
    t_begin;
    t_end;
    t_evt(8'h03);
    t_evt(8'h04);
    t_refuse;
    tally_and_finish;
  end
  initial begin
    #500000;
    miscompares++;
    tally_and_finish;
  end
endmodule // drs_top_tb_top
